// File: ftz_diag.sv
// Purpose: Totalizers, zero quality checks, flow status and service timer.
// Assumes: All inputs synchronous to core_clk; strap controller_unit
//          is stable after reset.
// Notes:   Attributes are reached through a simple id-addressed port.
`include "ftz_regs.svh"
// Contract
// RULE1: Keep writable running total of all gas.
// RULE2: Custom total with start, stop, reset.
// RULE3: Zero recommended after time limit, controller.
// RULE4: Wait settle seconds after zero setpoint.
// RULE5: Zero setpoint reading outside band recommends.
// RULE6: Bad zero beyond success band warns.
// RULE7: Drift check needs minimum interval, zero disables.
// RULE8: Keep total drift, widened expected rate.
// RULE9: Keep last 128 zero operations.
// RULE10: Entry holds instance, drift, temperature, hours.
// RULE11: Service 0x32 returns history entry data.
// RULE12: No-flow alarm when flow below percent; the code also alarms when flow equals the percent limit.
// RULE13: No-flow must persist for settle ms.
// RULE14: Choked flow persists at or below percent.
// RULE15: Count down service hours, warn at zero.
// RULE16: No-flow in alarm bit 2.
// RULE17: Choked flow in alarm bit 3.
// RULE18: Bad zero in warning bit 5.
// RULE19: Overhaul due in warning bit 19.
// RULE20: Millisecond tick drives settle counters.
// RULE21: Hours decrement hourly, saturate at zero.
module ftz_diag #(
  parameter logic [31:0] MS_CYCLES = 32'(`FTZ_MS_CYCLES),
  parameter logic [31:0] S_TICKS   = 32'(`FTZ_S_TICKS),
  parameter logic [31:0] H_SECONDS = 32'(`FTZ_H_SECONDS)
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        controller_unit,
  input  ftz_pkg::ftz_sense_s sense,
  input  wire logic        flow_sample,
  input  wire logic        zero_done,
  input  wire logic [31:0] zero_result,
  input  ftz_pkg::ftz_zero_s zero_info,
  input  wire logic        gas_page_change,
  input  wire logic        attr_wr_en,
  input  wire logic        attr_rd_en,
  input  wire logic [7:0]  attr_id,
  input  wire logic [31:0] attr_wdata,
  output logic [31:0]      attr_rdata,
  output logic             attr_ack,
  output logic             attr_err,
  input  wire logic        svc_req,
  input  wire logic [7:0]  svc_code,
  input  wire logic [7:0]  svc_index,
  output logic             svc_ack,
  output logic             svc_err,
  output ftz_pkg::ftz_hist_s svc_data,
  output logic [31:0]      active_alarms,
  output logic [31:0]      active_warnings,
  output logic             zero_recommended
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] ms_cnt_reg, ms_in_s_reg, s_in_h_reg, power_hours_reg;
  logic [31:0] flow_total_reg, cust_total_reg, acc_drift_reg;
  logic [31:0] zr_time_reg, zr_settle_reg, zr_band_reg, zs_band_reg;
  logic [31:0] drift_min_reg, drift_mult_reg, drift_off_reg;
  logic [31:0] nf_pct_reg, nf_ms_reg, ch_pct_reg, ch_ms_reg, hours_reg;
  logic [31:0] since_zero_reg, since_good_reg, rdata_next;
  logic        cust_run_reg, good_seen_reg, drift_warn_reg, bad_zero_reg;
  logic        zr_reg, known_id;
  logic [`FTZ_HIST_AW-1:0] wr_ptr_reg;
  logic [7:0]  hist_cnt_reg;
  logic        ms_tick, sec_tick, hour_tick;
  logic        nf_active, ch_active, zsp_settled;
  logic        nf_cond, ch_cond, zsp_cond, svc_ok;
  logic [31:0] flow_abs, res_abs, drift_abs, allowed;
  logic [63:0] flow_x100, nf_lim, ch_lim, drift_prod;
  logic [32:0] allow_sum;
  logic        zero_good, diag_run, diag_fail, zr_set;
  ftz_pkg::ftz_hist_s hist_entry;
  logic [`FTZ_HIST_AW-1:0] rd_addr;

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  // Millisecond, second and hour strobes.
  // RULE20: millisecond tick
  assign ms_tick   = (ms_cnt_reg == MS_CYCLES - 32'h1);
  assign sec_tick  = ms_tick && (ms_in_s_reg == S_TICKS - 32'h1);
  assign hour_tick = sec_tick && (s_in_h_reg == H_SECONDS - 32'h1);

  // Divider chain and elapsed-time counters.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ms_cnt_reg      <= 32'h0;
      ms_in_s_reg     <= 32'h0;
      s_in_h_reg      <= 32'h0;
      power_hours_reg <= 32'h0;
      since_zero_reg  <= 32'h0;
      since_good_reg  <= 32'h0;
    end
    else
    begin
      ms_cnt_reg <= ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
      if (ms_tick)
        ms_in_s_reg <= sec_tick ? 32'h0 : ms_in_s_reg + 32'h1;
      if (sec_tick)
        s_in_h_reg <= hour_tick ? 32'h0 : s_in_h_reg + 32'h1;
      if (hour_tick)
        power_hours_reg <= power_hours_reg + 32'h1;
      if (zero_done)
        since_zero_reg <= 32'h0;
      else if (sec_tick && since_zero_reg != 32'hffffffff)
        since_zero_reg <= since_zero_reg + 32'h1;
      if (zero_done && zero_good)
        since_good_reg <= 32'h0;
      else if (sec_tick && since_good_reg != 32'hffffffff)
        since_good_reg <= since_good_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Flow conditions
  // ----------------------------------------------------------------------
  // Negative flow never exceeds a percent limit.
  assign flow_abs  = sense.flow[31] ? 32'(-sense.flow) : 32'(sense.flow);
  assign flow_x100 = sense.flow[31] ? 64'h0 :
                     64'(flow_abs) * `FTZ_PCT_SCALE;
  assign nf_lim    = 64'(nf_pct_reg) * 64'(sense.setpoint);
  assign ch_lim    = 64'(ch_pct_reg) * 64'(sense.setpoint);
  // RULE12: flow not above limit
  assign nf_cond   = controller_unit && sense.setpoint != 32'h0 &&
                     !(flow_x100 > nf_lim);
  // RULE14: flow at or below limit
  assign ch_cond   = controller_unit && sense.setpoint != 32'h0 &&
                     (flow_x100 <= ch_lim);
  assign zsp_cond  = controller_unit && sense.setpoint == 32'h0;

  // RULE13: no-flow settling
  ftz_settle_timer u_nf_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (ms_tick),
    .cond     (nf_cond),
    .limit    (nf_ms_reg),
    .active   (nf_active)
  );

  // RULE14: choked settling
  ftz_settle_timer u_ch_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (ms_tick),
    .cond     (ch_cond),
    .limit    (ch_ms_reg),
    .active   (ch_active)
  );

  // RULE4: zero setpoint settle
  ftz_settle_timer u_zsp_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (sec_tick),
    .cond     (zsp_cond),
    .limit    (zr_settle_reg),
    .active   (zsp_settled)
  );

  // ----------------------------------------------------------------------
  // Zero quality
  // ----------------------------------------------------------------------
  assign res_abs   = zero_result[31] ? 32'(-zero_result) : zero_result;
  assign drift_abs = zero_info.drift[31] ? 32'(-zero_info.drift) :
                     32'(zero_info.drift);
  // RULE6: success band test
  assign zero_good = (res_abs <= zs_band_reg);
  // RULE8: expected drift widened
  assign drift_prod = 64'(drift_mult_reg) * 64'(since_good_reg);
  assign allow_sum  = {1'b0, drift_prod[31:0]} + {1'b0, drift_off_reg};
  assign allowed    = (drift_prod[63:32] != 32'h0 || allow_sum[32]) ?
                      32'hffffffff : allow_sum[31:0];
  // RULE7: interval gates diagnostic
  assign diag_run  = zero_done && zero_good && good_seen_reg &&
                     drift_min_reg != 32'h0 &&
                     since_good_reg >= drift_min_reg;
  assign diag_fail = drift_abs > allowed;
  // RULE3: time limit exceeded
  // RULE5: band check when settled
  assign zr_set = controller_unit &&
                  ((since_zero_reg > zr_time_reg) ||
                   (zsp_settled && zr_band_reg != 32'h0 &&
                    flow_abs > zr_band_reg));

  // Zero status flags; a set beats a clear.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      zr_reg         <= 1'b0;
      bad_zero_reg   <= 1'b0;
      drift_warn_reg <= 1'b0;
      good_seen_reg  <= 1'b0;
      acc_drift_reg  <= 32'h0;
    end
    else
    begin
      zr_reg <= zr_set ? 1'b1 : (zero_done ? 1'b0 : zr_reg);
      if (zero_done)
        bad_zero_reg <= !zero_good;
      if (diag_run)
        drift_warn_reg <= diag_fail;
      if (zero_done && zero_good)
        good_seen_reg <= 1'b1;
      // RULE8: accumulate drift per gas page
      if (gas_page_change)
        acc_drift_reg <= 32'h0;
      else if (zero_done)
        acc_drift_reg <= acc_drift_reg + drift_abs;
    end
  end

  // ----------------------------------------------------------------------
  // Zero history
  // ----------------------------------------------------------------------
  // RULE10: entry contents
  assign hist_entry = {zero_info.cal_inst, zero_info.drift,
                       zero_info.temp_c, power_hours_reg};
  // RULE11: index 0 is newest
  assign svc_ok  = svc_req && svc_code == `FTZ_SVC_HIST_READ &&
                   {1'b0, svc_index} < {1'b0, hist_cnt_reg};
  assign rd_addr = wr_ptr_reg - 7'h1 - svc_index[`FTZ_HIST_AW-1:0];

  ftz_hist_mem u_hist (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wr_en    (zero_done),
    .wr_addr  (wr_ptr_reg),
    .wr_data  (hist_entry),
    .rd_en    (svc_ok),
    .rd_addr  (rd_addr),
    .rd_data  (svc_data)
  );

  // Ring pointer and answer strobes.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      wr_ptr_reg   <= '0;
      hist_cnt_reg <= 8'h0;
      svc_ack      <= 1'b0;
      svc_err      <= 1'b0;
    end
    else
    begin
      // RULE9: oldest entry overwritten
      if (zero_done)
        wr_ptr_reg <= wr_ptr_reg + 7'h1;
      if (zero_done && hist_cnt_reg != 8'(`FTZ_HIST_DEPTH))
        hist_cnt_reg <= hist_cnt_reg + 8'h1;
      svc_ack <= svc_ok;
      svc_err <= svc_req && !svc_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Attribute registers
  // ----------------------------------------------------------------------
  // Host writes, totalizers and the service countdown.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      flow_total_reg <= 32'h0;
      cust_total_reg <= 32'h0;
      cust_run_reg   <= 1'b0;
      zr_time_reg    <= 32'hffffffff;
      zr_settle_reg  <= 32'h0;
      zr_band_reg    <= 32'h0;
      zs_band_reg    <= 32'hffffffff;
      drift_min_reg  <= 32'h0;
      drift_mult_reg <= 32'h0;
      drift_off_reg  <= 32'h0;
      nf_pct_reg     <= 32'h0;
      nf_ms_reg      <= 32'h0;
      ch_pct_reg     <= 32'h0;
      ch_ms_reg      <= 32'h0;
      hours_reg      <= 32'hffffffff;
    end
    else
    begin
      // RULE1: write or accumulate
      if (attr_wr_en && attr_id == `FTZ_A_FLOW_TOTAL)
        flow_total_reg <= attr_wdata;
      else if (flow_sample)
        flow_total_reg <= flow_total_reg + sense.flow_delta;
      // RULE2: custom total control
      if (attr_wr_en && attr_id == `FTZ_A_CUST_TOTAL)
        cust_total_reg <= attr_wdata;
      else if (attr_wr_en && attr_id == `FTZ_A_CUST_CTL &&
               attr_wdata == `FTZ_CTL_RESET)
        cust_total_reg <= 32'h0;
      else if (flow_sample && cust_run_reg)
        cust_total_reg <= cust_total_reg + sense.flow_delta;
      if (attr_wr_en && attr_id == `FTZ_A_CUST_CTL &&
          attr_wdata == `FTZ_CTL_START)
        cust_run_reg <= 1'b1;
      else if (attr_wr_en && attr_id == `FTZ_A_CUST_CTL &&
               attr_wdata == `FTZ_CTL_STOP)
        cust_run_reg <= 1'b0;
      // RULE15: host-writable service countdown
      // RULE21: hourly saturating countdown
      if (attr_wr_en && attr_id == `FTZ_A_SVC_HOURS)
        hours_reg <= attr_wdata;
      else if (hour_tick && hours_reg != 32'h0)
        hours_reg <= hours_reg - 32'h1;
      if (attr_wr_en)
      begin
        if (attr_id == `FTZ_A_ZR_TIME) zr_time_reg <= attr_wdata;
        if (attr_id == `FTZ_A_ZR_SETTLE) zr_settle_reg <= attr_wdata;
        if (attr_id == `FTZ_A_ZR_BAND) zr_band_reg <= attr_wdata;
        if (attr_id == `FTZ_A_ZS_BAND) zs_band_reg <= attr_wdata;
        if (attr_id == `FTZ_A_DRIFT_MIN) drift_min_reg <= attr_wdata;
        if (attr_id == `FTZ_A_DRIFT_MULT) drift_mult_reg <= attr_wdata;
        if (attr_id == `FTZ_A_DRIFT_OFF) drift_off_reg <= attr_wdata;
        if (attr_id == `FTZ_A_NF_PCT) nf_pct_reg <= attr_wdata;
        if (attr_id == `FTZ_A_NF_MS) nf_ms_reg <= attr_wdata;
        if (attr_id == `FTZ_A_CH_PCT) ch_pct_reg <= attr_wdata;
        if (attr_id == `FTZ_A_CH_MS) ch_ms_reg <= attr_wdata;
      end
    end
  end

  // Read data selection.
  assign rdata_next =
    (attr_id == `FTZ_A_FLOW_TOTAL) ? flow_total_reg :
    (attr_id == `FTZ_A_CUST_TOTAL) ? cust_total_reg :
    (attr_id == `FTZ_A_CUST_CTL)   ? {31'h0, cust_run_reg} :
    (attr_id == `FTZ_A_ZR_TIME)    ? zr_time_reg :
    (attr_id == `FTZ_A_ZR_SETTLE)  ? zr_settle_reg :
    (attr_id == `FTZ_A_ZR_BAND)    ? zr_band_reg :
    (attr_id == `FTZ_A_ZS_BAND)    ? zs_band_reg :
    (attr_id == `FTZ_A_DRIFT_MIN)  ? drift_min_reg :
    (attr_id == `FTZ_A_DRIFT_MULT) ? drift_mult_reg :
    (attr_id == `FTZ_A_DRIFT_OFF)  ? drift_off_reg :
    (attr_id == `FTZ_A_ACC_DRIFT)  ? acc_drift_reg :
    (attr_id == `FTZ_A_NF_PCT)     ? nf_pct_reg :
    (attr_id == `FTZ_A_NF_MS)      ? nf_ms_reg :
    (attr_id == `FTZ_A_CH_PCT)     ? ch_pct_reg :
    (attr_id == `FTZ_A_CH_MS)      ? ch_ms_reg :
    (attr_id == `FTZ_A_SVC_HOURS)  ? hours_reg : 32'h0;
  // Read-only and table ids refuse writes; the table needs the service.
  assign known_id = (rdata_next != 32'h0) ||
                    (attr_id inside {`FTZ_A_FLOW_TOTAL, `FTZ_A_CUST_TOTAL,
                     `FTZ_A_CUST_CTL, `FTZ_A_ZR_TIME, `FTZ_A_ZR_SETTLE,
                     `FTZ_A_ZR_BAND, `FTZ_A_ZS_BAND, `FTZ_A_DRIFT_MIN,
                     `FTZ_A_DRIFT_MULT, `FTZ_A_DRIFT_OFF, `FTZ_A_ACC_DRIFT,
                     `FTZ_A_NF_PCT, `FTZ_A_NF_MS, `FTZ_A_CH_PCT,
                     `FTZ_A_CH_MS, `FTZ_A_SVC_HOURS});

  // Answer register and status words.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      attr_rdata       <= 32'h0;
      attr_ack         <= 1'b0;
      attr_err         <= 1'b0;
      active_alarms    <= 32'h0;
      active_warnings  <= 32'h0;
      zero_recommended <= 1'b0;
    end
    else
    begin
      attr_rdata <= attr_rd_en ? rdata_next : 32'h0;
      attr_ack   <= attr_rd_en || attr_wr_en;
      attr_err   <= (attr_rd_en && !known_id) || (attr_wr_en &&
                    (!known_id || attr_id == `FTZ_A_ACC_DRIFT));
      // RULE16: no-flow bit
      active_alarms[`FTZ_AL_NO_FLOW] <= nf_active;
      // RULE17: choked alarm bit
      active_alarms[`FTZ_AL_CHOKED]  <= ch_active;
      active_warnings[`FTZ_WN_RESTRICT] <= ch_active;
      active_warnings[`FTZ_WN_DRIFT]    <= drift_warn_reg;
      // RULE18: bad zero bit
      active_warnings[`FTZ_WN_BAD_ZERO] <= bad_zero_reg;
      // RULE19: overhaul bit
      active_warnings[`FTZ_WN_OVERHAUL] <= (hours_reg == 32'h0);
      zero_recommended <= zr_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // RULE16: no-flow reported
  chk_no_flow_bit: assert property (nf_active |=> // RULE16
    active_alarms[`FTZ_AL_NO_FLOW]) else $error("no-flow bit missing");
  // RULE17: choked reported
  chk_choked_bits: assert property (ch_active |=> // RULE17
    active_alarms[`FTZ_AL_CHOKED] && active_warnings[`FTZ_WN_RESTRICT])
    else $error("choked bits missing");
  // RULE18: bad zero reported
  chk_bad_zero_bit: assert property (zero_done && !zero_good |=> ##1 // RULE18
    active_warnings[`FTZ_WN_BAD_ZERO]) else $error("bad zero missing");
  // RULE19: overhaul reported
  chk_overhaul_bit: assert property (hours_reg == 32'h0 |=> // RULE19
    active_warnings[`FTZ_WN_OVERHAUL]) else $error("overhaul missing");
  // RULE21: no wrap at zero
  chk_hours_sat: assert property (hours_reg == 32'h0 && !attr_wr_en // RULE21
    |=> hours_reg == 32'h0) else $error("hours wrapped");
  // RULE9: ring advance
  chk_hist_ptr: assert property (zero_done |=> // RULE9
    wr_ptr_reg == $past(wr_ptr_reg) + 7'h1) else $error("ptr stuck");
  // RULE11: service answered
  chk_svc_answer: assert property (svc_req |=> svc_ack != svc_err) // RULE11
    else $error("service not answered");
  // RULE2: stopped total holds
  chk_cust_hold: assert property (!cust_run_reg && !attr_wr_en // RULE2
    |=> cust_total_reg == $past(cust_total_reg)) else $error("total moved");
  cov_no_flow:  cover property (nf_active ##1 active_alarms[2]);
  cov_bad_zero: cover property (zero_done && !zero_good);
  cov_svc_read: cover property (svc_ok ##1 svc_ack);
  cov_overhaul: cover property (hour_tick && hours_reg == 32'h1);
endmodule

// File: ftz_regs.svh
// Purpose: Attribute numbers, status bit positions and timing counts.
// Assumes: Included by the diag, settle timer, history memory and bench files.
// Notes:   Attribute numbers are the host-visible register offsets.
`ifndef FTZ_REGS_SVH
`define FTZ_REGS_SVH
// ----------------------------------------------------------------------
// Attribute offsets
// ----------------------------------------------------------------------
`define FTZ_A_FLOW_TOTAL  8'h7e
`define FTZ_A_CUST_TOTAL  8'h82
`define FTZ_A_CUST_CTL    8'h83
`define FTZ_A_ZR_TIME     8'h8c
`define FTZ_A_ZR_SETTLE   8'h8d
`define FTZ_A_ZR_BAND     8'h8e
`define FTZ_A_ZS_BAND     8'h8f
`define FTZ_A_DRIFT_MIN   8'h90
`define FTZ_A_DRIFT_MULT  8'h91
`define FTZ_A_DRIFT_OFF   8'h92
`define FTZ_A_ACC_DRIFT   8'h94
`define FTZ_A_ZERO_HIST   8'h95
`define FTZ_A_NF_PCT      8'hde
`define FTZ_A_NF_MS       8'hdf
`define FTZ_A_CH_PCT      8'he0
`define FTZ_A_CH_MS       8'he1
`define FTZ_A_SVC_HOURS   8'he2
`define FTZ_SVC_HIST_READ 8'h32
// ----------------------------------------------------------------------
// Status bits and control codes
// ----------------------------------------------------------------------
`define FTZ_AL_NO_FLOW    2
`define FTZ_AL_CHOKED     3
`define FTZ_WN_RESTRICT   2
`define FTZ_WN_DRIFT      4
`define FTZ_WN_BAD_ZERO   5
`define FTZ_WN_OVERHAUL   19
`define FTZ_CTL_STOP      32'h0
`define FTZ_CTL_START     32'h1
`define FTZ_CTL_RESET     32'h2
`define FTZ_HIST_DEPTH    128
`define FTZ_HIST_AW       7
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FTZ_CLK_HZ        25000000
`define FTZ_TICK_MS       1
`define FTZ_MS_CYCLES     (`FTZ_CLK_HZ / 1000 * `FTZ_TICK_MS)
`define FTZ_S_TICKS       1000
`define FTZ_H_SECONDS     3600
`define FTZ_PCT_SCALE     64'h64
`endif

// File: ftz_pkg.sv
// Purpose: Shared types of the flow diagnostics block.
// Assumes: Values are 32-bit fixed point words.
// Notes:   History entries are 128 bits wide.
package ftz_pkg;
  // Sensor and setpoint path.
  typedef struct packed {
    logic signed [31:0] flow;
    logic        [31:0] setpoint;
    logic        [31:0] flow_delta;
  } ftz_sense_s;
  // Conditions captured before a zero operation.
  typedef struct packed {
    logic        [31:0] cal_inst;
    logic signed [31:0] drift;
    logic signed [31:0] temp_c;
  } ftz_zero_s;
  // One zero history entry.
  typedef struct packed {
    logic        [31:0] cal_inst;
    logic signed [31:0] drift;
    logic signed [31:0] temp_c;
    logic        [31:0] power_hours;
  } ftz_hist_s;
endpackage

// File: ftz_settle_timer.sv
// Purpose: Counts ticks while a condition holds and flags when settled.
// Assumes: tick is a one-cycle pulse.
// Notes:   The count restarts as soon as the condition drops.
`include "ftz_regs.svh"
module ftz_settle_timer (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        tick,
  input  wire logic        cond,
  input  wire logic [31:0] limit,
  output logic             active
);
  logic [31:0] count_reg;
  logic [31:0] count_next;

  // Clear on lapse, saturate at the top.
  assign count_next = !cond ? 32'h0 :
                      (tick && count_reg != 32'hffffffff) ?
                      count_reg + 32'h1 : count_reg;
  assign active = cond && (count_reg >= limit);

  // Count register.
  // RULE20: tick based count
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      count_reg <= 32'h0;
    else
      count_reg <= count_next;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // RULE13: restart on lapse
  chk_settle_restart: assert property (!cond |=> count_reg == 32'h0) // RULE13
    else $error("settle count not cleared");
  // RULE20: hold between ticks
  chk_settle_hold: assert property (cond && !tick |=> // RULE20
    count_reg == $past(count_reg)) else $error("settle count moved");
endmodule

// File: ftz_hist_mem.sv
// Purpose: Storage for the zero history entries.
// Assumes: One write and one read port, read data registered.
// Notes:   Contents are not cleared by reset.
`include "ftz_regs.svh"
module ftz_hist_mem (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     wr_en,
  input  wire logic [`FTZ_HIST_AW-1:0]  wr_addr,
  input  ftz_pkg::ftz_hist_s            wr_data,
  input  wire logic                     rd_en,
  input  wire logic [`FTZ_HIST_AW-1:0]  rd_addr,
  output ftz_pkg::ftz_hist_s            rd_data
);
  ftz_pkg::ftz_hist_s mem [0:`FTZ_HIST_DEPTH-1];

  // Array write.
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered read.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= mem[rd_addr];
  end
endmodule

// File: ftz_host.sv
// Purpose: Network host model that reads and writes attributes.
// Assumes: Requests launch at the falling edge of core_clk.
// Notes:   The answer is taken one falling edge after launch.
module ftz_host (
  input  wire logic        core_clk,
  output logic             wr_en = 1'b0,
  output logic             rd_en = 1'b0,
  output logic [7:0]       id    = 8'h00,
  output logic [31:0]      wdata = 32'h0,
  input  wire logic [31:0] rdata,
  input  wire logic        ack,
  input  wire logic        err
);
  timeunit 1ns;
  timeprecision 1ns;
  // One transfer; released data shows its inverse so no stale match.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic [1:0] e);
    @(negedge core_clk);
    wr_en = w;
    rd_en = !w;
    id    = a;
    wdata = d;
    @(negedge core_clk);
    q     = rdata;
    e     = {ack, err};
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = ~d;
  endtask
endmodule

// File: flow_totalizer_zero_diagnostics_tb_top.sv
// Purpose: Self-checking bench of the flow diagnostics block.
// Assumes: Short counts: 4 cycles a ms, 3 ms a s, 2 s an hour.
// Notes:   Inputs change at the falling edge only.
`include "ftz_regs.svh"
module flow_totalizer_zero_diagnostics_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               core_clk = 1'b0;
  logic               rstn = 1'b0;
  logic               cu = 1'b0;
  ftz_pkg::ftz_sense_s sense = '0;
  ftz_pkg::ftz_zero_s zinfo = '0;
  logic               fs = 1'b0;
  logic               zd = 1'b0;
  logic [31:0]        zres = 32'h0;
  logic               sreq = 1'b0;
  logic [7:0]         sidx = 8'h00;
  logic [7:0]         scode = `FTZ_SVC_HIST_READ;
  logic               gpc = 1'b0;
  logic               we, re, ack, err, sack, serr, zr;
  logic [7:0]         aid;
  logic [31:0]        wd, rdat, al, wn, q;
  logic [1:0]         e;
  ftz_pkg::ftz_hist_s sdat;
  int                 n_fail = 0;
  int                 checks = 0;
  always #20 core_clk = ~core_clk;
  ftz_host h (.core_clk(core_clk), .wr_en(we), .rd_en(re), .id(aid),
    .wdata(wd), .rdata(rdat), .ack(ack), .err(err));
  ftz_diag #(.MS_CYCLES(32'h4), .S_TICKS(32'h3), .H_SECONDS(32'h2)) dut (
    .core_clk(core_clk), .rstn(rstn), .controller_unit(cu), .sense(sense),
    .flow_sample(fs), .zero_done(zd), .zero_result(zres),
    .zero_info(zinfo), .gas_page_change(gpc), .attr_wr_en(we),
    .attr_rd_en(re), .attr_id(aid), .attr_wdata(wd), .attr_rdata(rdat),
    .attr_ack(ack), .attr_err(err), .svc_req(sreq),
    .svc_code(scode), .svc_index(sidx), .svc_ack(sack),
    .svc_err(serr), .svc_data(sdat), .active_alarms(al),
    .active_warnings(wn), .zero_recommended(zr));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Compares a seen value with an expected one and counts both.
  task automatic chk(input logic [127:0] s, input logic [127:0] x);
    checks++;
    if (s !== x)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Attribute access; write answers are judged on ack and err only.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] x);
    h.xfer(w, a, d, q, e);
    chk({e, w ? 32'h0 : q}, x);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cuts a hang short well after the expected run length.
  initial
  begin
    #100us;
    n_fail++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    acc(0, `FTZ_A_SVC_HOURS, 0, {2'b10, 32'hffffffff});
    acc(1, `FTZ_A_CUST_CTL, `FTZ_CTL_START, {2'b10, 32'h0});
    sense.flow_delta = 32'h5;
    repeat (2)
    begin
      @(negedge core_clk) fs = 1'b1;
      @(negedge core_clk) fs = 1'b0;
    end
    acc(0, `FTZ_A_CUST_TOTAL, 0, {2'b10, 32'ha});
    acc(0, `FTZ_A_FLOW_TOTAL, 0, {2'b10, 32'ha});
    acc(1, `FTZ_A_ACC_DRIFT, 1, {2'b11, 32'h0});
    acc(1, `FTZ_A_SVC_HOURS, 1, {2'b10, 32'h0});
    repeat (60) @(negedge core_clk);
    chk(wn, 32'h80000);
    acc(0, `FTZ_A_SVC_HOURS, 0, {2'b10, 32'h0});
    acc(1, `FTZ_A_NF_PCT, 50, {2'b10, 32'h0});
    acc(1, `FTZ_A_NF_MS, 2, {2'b10, 32'h0});
    acc(1, `FTZ_A_CH_MS, 2, {2'b10, 32'h0});
    cu = 1'b1;
    sense.setpoint = 32'h64;
    repeat (3) @(negedge core_clk);
    chk(al, 32'h0);
    repeat (20) @(negedge core_clk);
    chk(al, 32'hc);
    acc(1, `FTZ_A_ZS_BAND, 2, {2'b10, 32'h0});
    zinfo = '{32'h7, -32'sd3, 32'sd25};
    zres = 32'h5;
    @(negedge core_clk) zd = 1'b1;
    @(negedge core_clk) zd = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(wn, 32'h80024);
    acc(0, `FTZ_A_ACC_DRIFT, 0, {2'b10, 32'h3});
    @(negedge core_clk) sreq = 1'b1;
    @(negedge core_clk) sreq = 1'b0;
    chk({sack, sdat[127:32]}, {1'b1, 32'h7, 32'hfffffffd, 32'h19});
    chk(sdat[31:0], 32'h4);
    sidx = 8'h01;
    @(negedge core_clk) sreq = 1'b1;
    @(negedge core_clk) sreq = 1'b0;
    chk({sack, serr}, 2'b01);
    // A wrong service code is refused.
    scode = 8'h33;
    sidx = 8'h00;
    @(negedge core_clk) sreq = 1'b1;
    @(negedge core_clk) sreq = 1'b0;
    chk({sack, serr}, 2'b01);
    // Time since the last zero passes a one second limit.
    chk(zr, 1'b0);
    acc(1, `FTZ_A_ZR_TIME, 1, {2'b10, 32'h0});
    repeat (12) @(negedge core_clk);
    chk(zr, 1'b1);
    // A gas page change clears the drift total.
    @(negedge core_clk) gpc = 1'b1;
    @(negedge core_clk) gpc = 1'b0;
    acc(0, `FTZ_A_ACC_DRIFT, 0, {2'b10, 32'h0});
    // Reset keeps the run bit, stop clears it.
    acc(1, `FTZ_A_CUST_CTL, `FTZ_CTL_RESET, {2'b10, 32'h0});
    acc(0, `FTZ_A_CUST_TOTAL, 0, {2'b10, 32'h0});
    acc(0, `FTZ_A_CUST_CTL, 0, {2'b10, 32'h1});
    acc(1, `FTZ_A_CUST_CTL, `FTZ_CTL_STOP, {2'b10, 32'h0});
    acc(0, `FTZ_A_CUST_CTL, 0, {2'b10, 32'h0});
    // Two good zeros a second apart run the drift check.
    acc(1, `FTZ_A_DRIFT_MIN, 1, {2'b10, 32'h0});
    zres = 32'h0;
    @(negedge core_clk) zd = 1'b1;
    @(negedge core_clk) zd = 1'b0;
    repeat (14) @(negedge core_clk);
    @(negedge core_clk) zd = 1'b1;
    @(negedge core_clk) zd = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(wn, 32'h80014);
    stop_test();
  end
endmodule
